/* pkg/accel_cfg_defines.svh */
`ifndef ACCEL_CFG_DEFINES_SVH
`define ACCEL_CFG_DEFINES_SVH

`define ADDR_OUT_RANGE_CFG 8'h0e
`define ADDR_HP_CUTOFF_CFG 8'h0f
`define ADDR_ORIENT_STATUS 8'h10

`define OUT_CFG_WMASK 8'hff
`define HP_CFG_WMASK 8'hff
`define CFG_RESET 8'h00

`define BIT_HPF_OUT 4
`define BIT_RANGE_LO 0
`define BIT_TAP_HPF_BYPASS 5
`define BIT_TAP_LPF_EN 4
`define BIT_CUTOFF_LO 0
`define BIT_ORIENT_CHANGED 7
`define BIT_LOCKOUT 6

`define SEL_RATE_800 3'h0
`define CUTOFF_BASE_MHZ 20'h03e80

`endif

/* pkg/accel_cfg_pkg.sv */
package accel_cfg_pkg;

typedef enum logic [1:0] {
	RANGE_2G = 2'h0,
	RANGE_4G = 2'h1,
	RANGE_8G = 2'h2,
	RANGE_RSVD = 2'h3
} range_t;

typedef enum logic [1:0] {
	OSM_NORMAL = 2'h0,
	OSM_LNLP = 2'h1,
	OSM_HIRES = 2'h2,
	OSM_LOWPOWER = 2'h3
} osm_t;

typedef enum logic [1:0] {
	PL_PORTRAIT_UP = 2'h0,
	PL_PORTRAIT_DOWN = 2'h1,
	PL_LAND_RIGHT = 2'h2,
	PL_LAND_LEFT = 2'h3
} pl_code_t;

typedef enum logic [1:0] {
	ST_STANDBY = 2'h0,
	ST_WAIT_FIRST = 2'h1,
	ST_TRACK = 2'h3
} orient_state_t;

endpackage

/* rtl/accel_range_hpf_config.sv */
`timescale 1ns/1ns
// What this block does
// R1 - Bit 4 of the range/filter register selects raw or high-pass data out.
// R2 - The range field picks 2 g, 4 g or 8 g at 0.244, 0.488, 0.976 mg/LSB.
// R3 - Both configuration registers reset to zero and are fully read/write.
// R4 - Bit 5 of the cutoff register removes the high-pass from the tap path.
// R5 - Bit 4 of the cutoff register inserts a low-pass into the tap path.
// R6 - The cutoff field gives 16 Hz at 800 Hz rate and halves per code step.
// R7 - Cutoff scales with rate and mode, except high-res which stays fixed.
// R8 - Six orientations: four portrait/landscape with lockout, plus face.
// R9 - Status bit 7 flags a change; bits 6 and 2:0 give the current orientation, bits 5:3 read zero.
// R10 - Reading the orientation status clears the pending orientation event.
// R11 - The change flag sets on first detection after activation or change.
// R12 - Codes: portrait up 00, down 01, land right 10, left 11; back is 1.
// R13 - Each of X, Y and Z is high-pass filtered on its own.
// R14 - Software must not write the reserved range code 11.
`include "accel_cfg_defines.svh"

module accel_range_hpf_config
	import accel_cfg_pkg::*;
#(
	parameter int DATA_W = 14
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Operating context
	input wire logic active_i,
	input wire logic [2:0] output_rate_i,
	input wire logic [1:0] osm_i,
	// Raw samples, one strobe per X/Y/Z set
	input wire logic sample_valid_i,
	input wire logic signed [DATA_W-1:0] x_i,
	input wire logic signed [DATA_W-1:0] y_i,
	input wire logic signed [DATA_W-1:0] z_i,
	// Orientation detector result
	input wire logic orient_valid_i,
	input wire logic [1:0] pl_code_i,
	input wire logic back_i,
	input wire logic tilt_lockout_i,
	// Outputs
	output logic out_valid_o,
	output logic signed [DATA_W-1:0] x_o,
	output logic signed [DATA_W-1:0] y_o,
	output logic signed [DATA_W-1:0] z_o,
	output logic signed [DATA_W-1:0] tap_x_o,
	output logic signed [DATA_W-1:0] tap_y_o,
	output logic signed [DATA_W-1:0] tap_z_o,
	output logic [1:0] range_select_o,
	output logic [19:0] cutoff_mhz_o,
	output logic orient_event_o
);

localparam int SH_W = 4;
localparam int ACC_W = DATA_W + 8;

typedef struct packed {
	logic [7:0] out_cfg;
	logic [7:0] hp_cfg;
	logic [1:0] pl_code;
	logic back;
	logic lockout;
	logic changed;
	orient_state_t ost;
	logic [2:0][ACC_W-1:0] hp_acc;
	logic [2:0][ACC_W-1:0] lp_acc;
	logic [2:0][DATA_W-1:0] out_d;
	logic [2:0][DATA_W-1:0] tap_d;
	logic out_valid;
	logic [7:0] rdata;
	logic [19:0] cutoff;
} state_t;

state_t state_reg;
state_t state_next;

////////////////////////////////////////////////////////////////////////////////

// Filter shift against 16 Hz: rate steps follow the mode, each code halves
// Rate index 0..7 is 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
function automatic logic [SH_W-1:0] hp_shift(input logic [1:0] sel,
		input logic [2:0] rate, input logic [1:0] mode);
	logic [SH_W-1:0] r;
	r = 4'h0;
	if (mode != OSM_HIRES) begin // [R7]
		case (rate)
		3'h0: r = 4'h0;
		3'h1: r = 4'h0;
		3'h2: r = 4'h1;
		3'h3: r = 4'h2;
		3'h4: r = 4'h3;
		3'h5: r = (mode == OSM_NORMAL) ? 4'h3 : 4'h5;
		3'h6: r = (mode == OSM_NORMAL) ? 4'h3 : 4'h6;
		default: r = (mode == OSM_NORMAL) ? 4'h3 : 4'h8;
		endcase
		// Low power sits one step lower at every rate below 800 Hz
		if (mode == OSM_LOWPOWER && rate != 3'h0) begin
			r = r + 4'h1;
		end
	end
	r = r + {2'h0, sel};
	return r; // [R6]
endfunction

function automatic logic [ACC_W-1:0] ext(input logic [DATA_W-1:0] d);
	return {{(ACC_W-DATA_W){d[DATA_W-1]}}, d};
endfunction

////////////////////////////////////////////////////////////////////////////////

always_comb begin
	logic [SH_W-1:0] sh;
	logic [ACC_W-1:0] hp_val;
	logic [ACC_W-1:0] raw;
	logic [ACC_W-1:0] tap_in;
	logic [DATA_W-1:0] samp;
	logic [1:0] ch;
	state_next = state_reg;
	sh = hp_shift(state_reg.hp_cfg[`BIT_CUTOFF_LO +: 2], output_rate_i,
		osm_i);
	hp_val = '0;
	raw = '0;
	tap_in = '0;
	samp = '0;
	ch = '0;
	state_next.out_valid = 1'b0;
	// Register writes
	if (reg_wr_i) begin
		if (reg_addr_i == `ADDR_OUT_RANGE_CFG) begin
			state_next.out_cfg = reg_wdata_i & `OUT_CFG_WMASK; // [R3]
		end else if (reg_addr_i == `ADDR_HP_CUTOFF_CFG) begin
			state_next.hp_cfg = reg_wdata_i & `HP_CFG_WMASK; // [R3]
		end
	end
	// Filters per axis: leaky integrator gives the low-frequency part
	if (sample_valid_i) begin
		for (int i = 0; i < 3; i++) begin
			samp = (i == 0) ? x_i : (i == 1) ? y_i : z_i;
			raw = ext(samp);
			hp_val = raw - (state_reg.hp_acc[i] >>> (sh + 4'h3)); // [R13]
			state_next.hp_acc[i] = state_reg.hp_acc[i]
				+ raw - (state_reg.hp_acc[i] >>> (sh + 4'h3));
			state_next.out_d[i] = state_reg.out_cfg[`BIT_HPF_OUT]
				? hp_val[DATA_W-1:0] : samp; // [R1]
			tap_in = state_reg.hp_cfg[`BIT_TAP_HPF_BYPASS]
				? raw : hp_val; // [R4]
			state_next.lp_acc[i] = state_reg.lp_acc[i]
				+ ((tap_in - state_reg.lp_acc[i]) >>> 2);
			state_next.tap_d[i] = state_reg.hp_cfg[`BIT_TAP_LPF_EN]
				? state_next.lp_acc[i][DATA_W-1:0]
				: tap_in[DATA_W-1:0]; // [R5]
		end
		state_next.out_valid = 1'b1;
	end
	state_next.cutoff = `CUTOFF_BASE_MHZ >> sh; // [R6] [R7]
	// Orientation tracking
	case (state_reg.ost)
	ST_STANDBY: begin
		if (active_i) begin
			state_next.ost = ST_WAIT_FIRST;
		end
	end
	ST_WAIT_FIRST: begin
		if (!active_i) begin
			state_next.ost = ST_STANDBY;
		end else if (orient_valid_i) begin
			ch[0] = 1'b1; // [R11]
			state_next.ost = ST_TRACK;
		end
	end
	ST_TRACK: begin
		if (!active_i) begin
			state_next.ost = ST_STANDBY;
		end else if (orient_valid_i) begin
			ch[1] = (pl_code_i != state_reg.pl_code)
				|| (back_i != state_reg.back)
				|| (tilt_lockout_i != state_reg.lockout); // [R11]
		end
	end
	default: state_next.ost = ST_STANDBY;
	endcase
	if (orient_valid_i && active_i) begin
		state_next.pl_code = pl_code_i; // [R8] [R12]
		state_next.back = back_i; // [R12]
		state_next.lockout = tilt_lockout_i; // [R8]
	end
	// Read data and clear-on-read; a new change wins over the clear
	state_next.rdata = 8'h00;
	if (reg_rd_i) begin
		case (reg_addr_i)
		`ADDR_OUT_RANGE_CFG: state_next.rdata = state_reg.out_cfg;
		`ADDR_HP_CUTOFF_CFG: state_next.rdata = state_reg.hp_cfg;
		`ADDR_ORIENT_STATUS: begin
			state_next.rdata = {state_reg.changed, state_reg.lockout,
				3'h0, state_reg.pl_code, state_reg.back}; // [R9]
			state_next.changed = 1'b0; // [R10]
		end
		default: state_next.rdata = 8'h00;
		endcase
	end
	if (ch != 2'h0) begin
		state_next.changed = 1'b1; // [R11]
	end
end

always_ff @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		state_reg <= '0; // [R3]
		state_reg.out_cfg <= `CFG_RESET;
		state_reg.hp_cfg <= `CFG_RESET;
		state_reg.ost <= ST_STANDBY;
		state_reg.cutoff <= `CUTOFF_BASE_MHZ;
	end else begin
		state_reg <= state_next;
	end
end

////////////////////////////////////////////////////////////////////////////////

assign reg_rdata_o = state_reg.rdata;
assign out_valid_o = state_reg.out_valid;
assign x_o = state_reg.out_d[0];
assign y_o = state_reg.out_d[1];
assign z_o = state_reg.out_d[2];
assign tap_x_o = state_reg.tap_d[0];
assign tap_y_o = state_reg.tap_d[1];
assign tap_z_o = state_reg.tap_d[2];
assign range_select_o = state_reg.out_cfg[`BIT_RANGE_LO +: 2]; // [R2] [R14]
assign cutoff_mhz_o = state_reg.cutoff;
assign orient_event_o = state_reg.changed; // [R9]

endmodule // accel_range_hpf_config

/* sim/accel_cfg_monitor.sv */
`timescale 1ns/1ns
module accel_cfg_monitor(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic active_i,
	input wire logic [1:0] osm_i,
	input wire logic sample_valid_i,
	input wire logic orient_valid_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic out_valid_o,
	input wire logic [19:0] cutoff_mhz_o,
	input wire logic orient_event_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire logic st_rd = reg_rd_i && reg_addr_i == 8'h10;
	property p_oval; sample_valid_i |=> out_valid_o; endproperty
	a_oval: assert property (p_oval) else $error("no out valid");
	property p_flag;
		st_rd |=> reg_rdata_o[7] == $past(orient_event_o);
	endproperty
	a_flag: assert property (p_flag) else $error("flag bit");
	property p_zero; st_rd |=> reg_rdata_o[5:3] == 3'h0; endproperty
	a_zero: assert property (p_zero) else $error("status pad");
	property p_clr; st_rd && !orient_valid_i |=> !orient_event_o; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_set;
		$rose(orient_event_o) |-> $past(orient_valid_i);
	endproperty
	a_set: assert property (p_set) else $error("stray set");
	property p_hold; orient_event_o && !st_rd |=> orient_event_o; endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_stby;
		!active_i && !orient_event_o |=> !orient_event_o;
	endproperty
	a_stby: assert property (p_stby) else $error("standby set");
	property p_hires;
		$past(osm_i) == 2'h2 |-> cutoff_mhz_o inside {20'h03e80, 20'h01f40,
			20'h00fa0, 20'h007d0};
	endproperty
	a_hires: assert property (p_hires) else $error("hires cutoff");
	// In high resolution a rate change alone must leave the cutoff alone
	property p_hrate;
		$past(osm_i) == 2'h2 && $past(osm_i, 2) == 2'h2
			&& !$past(reg_wr_i, 2) |-> $stable(cutoff_mhz_o);
	endproperty
	a_hrate: assert property (p_hrate) else $error("hires rate");
	c_ev: cover property (orient_event_o);
	c_rd: cover property (st_rd && orient_event_o);
	c_out: cover property (out_valid_o);
endmodule // accel_cfg_monitor

bind accel_range_hpf_config accel_cfg_monitor mon_u(.clk_i(clk_i),
	.nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_wr_i(reg_wr_i),
	.active_i(active_i), .osm_i(osm_i), .sample_valid_i(sample_valid_i),
	.orient_valid_i(orient_valid_i), .reg_rdata_o(reg_rdata_o),
	.out_valid_o(out_valid_o), .cutoff_mhz_o(cutoff_mhz_o),
	.orient_event_o(orient_event_o));

/* sim/host_port.sv */
`timescale 1ns/1ns
module host_port(
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o
);
	initial begin
		{addr_o, wr_o, rd_o, wdata_o} = '0;
	end
	// Callers never hand over the reserved range code
	task wr(input logic [7:0] a, d);
		@(negedge clk_i);
		{addr_o, wdata_o, wr_o} = {a, d, 1'b1};
		@(negedge clk_i);
		{addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		{addr_o, rd_o} = {a, 1'b1};
		@(negedge clk_i);
		{addr_o, rd_o} = {~a, 1'b0};
		d = rdata_i;
	endtask
endmodule // host_port

/* sim/accel_range_hpf_config_tb.sv */
`timescale 1ns/1ns
module accel_range_hpf_config_tb;
	import accel_cfg_pkg::*;
	logic clk_i = 0, nrst_i = 0, act = 0, sv = 0, ov = 0, bk = 0, lk = 0;
	logic signed [13:0] y = 0, yo, zo, tx, ty, tz;
	logic [2:0] rate = 0;
	logic [1:0] osm = 0, pl = 0, rs;
	logic signed [13:0] x = 0, xo;
	logic [7:0] a, wd, rdat;
	logic w, r, oval, ev;
	logic [19:0] cut;
	int mismatches = 0, checks_done = 0;
	always #5 clk_i = ~clk_i;
	host_port hu(.clk_i(clk_i), .rdata_i(rdat), .addr_o(a), .wr_o(w),
		.rd_o(r), .wdata_o(wd));
	accel_range_hpf_config dut_u(.clk_i(clk_i), .nrst_i(nrst_i),
		.reg_addr_i(a), .reg_wr_i(w), .reg_rd_i(r), .reg_wdata_i(wd),
		.reg_rdata_o(rdat), .active_i(act), .output_rate_i(rate),
		.osm_i(osm), .sample_valid_i(sv), .x_i(x), .y_i(y), .z_i(x),
		.orient_valid_i(ov), .pl_code_i(pl), .back_i(bk),
		.tilt_lockout_i(lk), .out_valid_o(oval), .x_o(xo), .y_o(yo),
		.z_o(zo), .tap_x_o(tx), .tap_y_o(ty), .tap_z_o(tz),
		.range_select_o(rs),
		.cutoff_mhz_o(cut), .orient_event_o(ev));
	task chk(input logic [19:0] g, e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task rd(input logic [7:0] ad, e);
		logic [7:0] d;
		hu.rd(ad, d);
		chk({12'h000, d}, {12'h000, e});
	endtask
	task orient(input logic [1:0] c, input logic l);
		@(negedge clk_i);
		{ov, pl, bk, lk} = {1'b1, c, 1'b1, l};
		@(negedge clk_i);
		ov = 0;
	endtask
	// One sample set; Y stays at zero to show the axes do not mix
	task samp(input logic [13:0] eo, et);
		@(negedge clk_i);
		{sv, x} = {1'b1, 14'h0064};
		@(negedge clk_i);
		sv = 0;
		chk({oval, 5'h00, xo}, {1'b1, 5'h00, eo});
		chk({6'h00, zo}, {6'h00, eo});
		chk({6'h00, tx}, {6'h00, et});
		chk({6'h00, tz}, {6'h00, et});
		chk({6'h00, yo}, 20'h00000);
		chk({6'h00, ty}, 20'h00000);
	endtask
	task cut_at(input logic [2:0] rt, input logic [1:0] m,
		input logic [19:0] e);
		{rate, osm} = {rt, m};
		repeat (2) @(negedge clk_i);
		chk(cut, e);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk_i);
		nrst_i = 1;
		rd(8'h0e, 8'h00);
		rd(8'h0f, 8'h00);
		chk(cut, 20'h03e80);
		for (int i = 0; i < 3; i++) begin
			hu.wr(8'h0e, 8'h10 | 8'(i));
			@(negedge clk_i);
			chk({18'h0, rs}, 20'(i));
		end
		rd(8'h0e, 8'h12);
		hu.wr(8'h0f, 8'h30);
		rd(8'h0f, 8'h30);
		for (int i = 0; i < 4; i++) begin
			hu.wr(8'h0f, 8'(i));
			cut_at(3'h0, 2'h0, 20'h03e80 >> i);
		end
		hu.wr(8'h0f, 8'h00);
		cut_at(3'h2, 2'h0, 20'h01f40);
		cut_at(3'h3, 2'h2, 20'h03e80);
		cut_at(3'h5, 2'h2, 20'h03e80);
		cut_at(3'h1, 2'h3, 20'h01f40);
		cut_at(3'h5, 2'h1, 20'h001f4);
		cut_at(3'h7, 2'h0, 20'h007d0);
		cut_at(3'h0, 2'h0, 20'h03e80);
		hu.wr(8'h0e, 8'h00);
		samp(14'h0064, 14'h0064);
		hu.wr(8'h0e, 8'h10);
		samp(14'h0058, 14'h0058);
		hu.wr(8'h0f, 8'h20);
		samp(14'h004d, 14'h0064);
		hu.wr(8'h0f, 8'h10);
		samp(14'h0043, 14'h003a);
		$display("config tests done");
		orient(2'h0, 1'b0);
		chk(ev, 1'b0);
		act = 1;
		orient(2'h2, 1'b0);
		chk(ev, 1'b1);
		rd(8'h10, 8'h85);
		rd(8'h10, 8'h05);
		orient(2'h3, 1'b0);
		rd(8'h10, 8'h87);
		orient(2'h3, 1'b1);
		rd(8'h10, 8'hc7);
		orient(2'h3, 1'b1);
		rd(8'h10, 8'h47);
		act = 0;
		@(negedge clk_i);
		act = 1;
		orient(2'h3, 1'b1);
		rd(8'h10, 8'hc7);
		$display("orientation tests done");
		nrst_i = 0;
		repeat (2) @(negedge clk_i);
		nrst_i = 1;
		rd(8'h0e, 8'h00);
		rd(8'h0f, 8'h00);
		rd(8'h10, 8'h00);
		chk(cut, 20'h03e80);
		$display("reset tests done");
		finish_test;
	end
	initial begin
		#100000;
		mismatches++;
		finish_test;
	end
endmodule // accel_range_hpf_config_tb
